//--- pin_ctrl_pkg.sv
// shared constants and types for the reset and mode pin control ends
package pin_ctrl_pkg;

    // reset output pulse length in bus cycles
    localparam int unsigned RESET_PULSE_CYCLES = 66;
    // debug serial bit timing, in debug clock cycles (debug clock = bus)
    localparam int unsigned BIT_CYCLES         = 16;
    localparam int unsigned LOW_CYCLES_ONE     = 4;
    localparam int unsigned LOW_CYCLES_ZERO    = 13;
    localparam int unsigned SAMPLE_CYCLE       = 10;

    // reset cause register field positions
    localparam int unsigned CAUSE_POR_POS   = 7;
    localparam int unsigned CAUSE_PIN_POS   = 6;
    localparam int unsigned CAUSE_WDOG_POS  = 5;
    localparam int unsigned CAUSE_FORCE_POS = 2;
    localparam int unsigned CAUSE_LV_POS    = 1;
    localparam logic [7:0]  CAUSE_RESET_VAL = 8'h80;

    // debug command codes (values are arbitrary)
    localparam logic [7:0] CMD_BACKGROUND  = 8'h90;
    localparam logic [7:0] CMD_FORCE_RESET = 8'h81;

    typedef enum logic [1:0] {
        ST_STRAP,
        ST_RUN,
        ST_PULSE,
        ST_RELEASE
    } seq_state_t;

endpackage

//--- pin_link_if.sv
// two shared pins between the device and the debug pod / reset source
`timescale 1ns/10ps
interface pin_link_if;
    logic rst_dev_o;
    logic rst_dev_oe_n;
    logic rst_host_o;
    logic rst_host_oe_n;
    logic rst_pullup;
    logic dbg_dev_o;
    logic dbg_dev_oe_n;
    logic dbg_host_o;
    logic dbg_host_oe_n;
    logic dbg_pullup;
    logic rst_level;
    logic dbg_level;

    // wired level: any driven low wins, otherwise high (pulled or speedup)
    assign rst_level = !((!rst_dev_oe_n && !rst_dev_o) ||
                         (!rst_host_oe_n && !rst_host_o));
    assign dbg_level = !((!dbg_dev_oe_n && !dbg_dev_o) ||
                         (!dbg_host_oe_n && !dbg_host_o));

    modport device (output rst_dev_o, rst_dev_oe_n, rst_pullup,
                    output dbg_dev_o, dbg_dev_oe_n, dbg_pullup,
                    input  rst_level, dbg_level);
    modport host   (output rst_host_o, rst_host_oe_n,
                    output dbg_host_o, dbg_host_oe_n,
                    input  rst_level, dbg_level, rst_pullup, dbg_pullup);
endinterface

//--- debug_bit_engine.sv
// one bit time of the single-wire debug protocol, send and receive
`timescale 1ns/10ps
module debug_bit_engine
    import pin_ctrl_pkg::*;
(
    input  wire logic mclk_in,
    input  wire logic resetn_in,
    input  wire logic rx_enable_in,
    input  wire logic tx_start_in,
    input  wire logic tx_bit_in,
    input  wire logic pin_level_in,
    output logic      tx_busy_out,
    output logic      pin_out,
    output logic      pin_oe_n_out,
    output logic      rx_valid_out,
    output logic      rx_bit_out
);
    logic [4:0] tx_cnt_reg;
    logic       tx_active_reg;
    logic       tx_bit_reg;
    logic [4:0] rx_cnt_reg;
    logic       rx_active_reg;
    logic       level_prev_reg;
    logic       rx_valid_reg;
    logic       rx_bit_reg;

    wire  [4:0] low_len = tx_bit_reg ? 5'(LOW_CYCLES_ONE)
                                     : 5'(LOW_CYCLES_ZERO);
    wire        drive_low = tx_active_reg && (tx_cnt_reg < low_len);
    wire        speedup   = tx_active_reg && (tx_cnt_reg == low_len);
    wire        fall      = level_prev_reg && !pin_level_in;

    // pseudo open-drain: low phase, one driven-high pulse, then release
    assign pin_out      = speedup;
    assign pin_oe_n_out = !(drive_low || speedup);
    assign tx_busy_out  = tx_active_reg;
    assign rx_valid_out = rx_valid_reg;
    assign rx_bit_out   = rx_bit_reg;

    // sender: a bit time always spans the full bit cycle count
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            tx_active_reg <= 1'b0;
            tx_cnt_reg    <= 5'h00;
            tx_bit_reg    <= 1'b0;
        end else if (!tx_active_reg) begin
            tx_active_reg <= tx_start_in;
            tx_bit_reg    <= tx_bit_in;
            tx_cnt_reg    <= 5'h00;
        end else begin
            tx_cnt_reg <= tx_cnt_reg + 5'h01;
            if (tx_cnt_reg == 5'(BIT_CYCLES - 1)) begin
                tx_active_reg <= 1'b0;
            end
        end
    end

    // receiver: a falling edge opens a bit, the level is sampled mid-way
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            rx_active_reg  <= 1'b0;
            rx_cnt_reg     <= 5'h00;
            level_prev_reg <= 1'b1;
            rx_valid_reg   <= 1'b0;
            rx_bit_reg     <= 1'b0;
        end else begin
            level_prev_reg <= pin_level_in;
            rx_valid_reg   <= 1'b0;
            if (!rx_enable_in) begin
                rx_active_reg <= 1'b0;
            end else if (!rx_active_reg) begin
                rx_active_reg <= fall;
                rx_cnt_reg    <= 5'h01;
            end else begin
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
                if (rx_cnt_reg == 5'(SAMPLE_CYCLE)) begin
                    rx_valid_reg <= 1'b1;
                    rx_bit_reg   <= pin_level_in;
                end
                if (rx_cnt_reg == 5'(BIT_CYCLES - 1)) begin
                    rx_active_reg <= 1'b0;
                end
            end
        end
    end
endmodule

//--- pin_ctrl_device.sv
// device end: reset pin, mode strap, debug pin and reset sequencing
`timescale 1ns/10ps

module pin_ctrl_device
    import pin_ctrl_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    pin_link_if.device      link,
    input  wire logic       reset_pin_enable_in,
    input  wire logic       debug_pin_disable_in,
    input  wire logic       select_crystal_in,
    input  wire logic       wdog_reset_req_in,
    input  wire logic       low_voltage_req_in,
    input  wire logic       port_a_line_five_data_in,
    input  wire logic       port_a_line_five_drive_in,
    input  wire logic       port_a_line_four_data_in,
    output logic            sys_reset_out,
    output logic            background_mode_out,
    output logic            reset_pin_enable_out,
    output logic            debug_pin_enable_out,
    output logic            clock_internal_out,
    output logic [7:0]      reset_cause_out,
    output logic            port_a_line_five_level_out,
    output logic            debug_cmd_valid_out,
    output logic [7:0]      debug_cmd_out
);
    seq_state_t state_reg;
    logic [6:0] pulse_cnt_reg;
    logic [7:0] cause_reg;
    logic       background_reg;
    logic       rst_pin_en_reg;
    logic       dbg_pin_en_reg;
    logic       armed_reg;
    logic       forced_reg;
    logic       clk_internal_reg;
    logic [7:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic       cmd_valid_reg;
    logic [7:0] cmd_reg;

    logic       rx_valid;
    logic       rx_bit;
    logic       eng_pin;
    logic       eng_oe_n;

    // reset sources seen while running
    wire running    = (state_reg == ST_RUN);
    wire pin_req    = running && rst_pin_en_reg && !link.rst_level;
    wire [7:0] rx_byte = {shift_reg[6:0], rx_bit};
    wire byte_done  = running && rx_valid && (bit_cnt_reg == 3'h7);
    wire force_req  = byte_done && armed_reg &&
                      (rx_byte == CMD_FORCE_RESET);
    wire wdog_req   = running && wdog_reset_req_in;
    wire lv_req     = running && low_voltage_req_in;
    wire any_req    = pin_req || wdog_req || lv_req || force_req;

    // one-hot cause; pin outranks internal sources, force is lowest
    wire [7:0] new_cause =
        pin_req  ? 8'(1 << CAUSE_PIN_POS)  :
        wdog_req ? 8'(1 << CAUSE_WDOG_POS) :
        lv_req   ? 8'(1 << CAUSE_LV_POS)   :
                   8'(1 << CAUSE_FORCE_POS);

    // pin protocol only while running and the debug pin is enabled
    wire dbg_serial = running && dbg_pin_en_reg;

    debug_bit_engine u_engine (
        .mclk_in      (mclk_in),
        .resetn_in    (resetn_in),
        .rx_enable_in (dbg_serial),
        .tx_start_in  (1'b0),
        .tx_bit_in    (1'b0),
        .pin_level_in (link.dbg_level),
        .tx_busy_out  (),
        .pin_out      (eng_pin),
        .pin_oe_n_out (eng_oe_n),
        .rx_valid_out (rx_valid),
        .rx_bit_out   (rx_bit)
    );

    // ***********************************************************
    // pin drive
    // ***********************************************************

    // reset pin: open-drain low only during the pulse; else port line
    assign link.rst_dev_o    = rst_pin_en_reg ? 1'b0
                                              : port_a_line_five_data_in;
    assign link.rst_dev_oe_n = rst_pin_en_reg ? (state_reg != ST_PULSE)
                                              : !port_a_line_five_drive_in;
    assign link.rst_pullup   = rst_pin_en_reg;
    // debug pin: released in reset so the strap can be read
    assign link.dbg_dev_o    = dbg_serial ? eng_pin
                                          : port_a_line_four_data_in;
    assign link.dbg_dev_oe_n = dbg_pin_en_reg ? (eng_oe_n || !running)
                                              : !running;
    assign link.dbg_pullup   = dbg_pin_en_reg;

    assign sys_reset_out              = !running;
    assign background_mode_out        = background_reg;
    assign reset_pin_enable_out       = rst_pin_en_reg;
    assign debug_pin_enable_out       = dbg_pin_en_reg;
    assign clock_internal_out         = clk_internal_reg;
    assign reset_cause_out            = cause_reg;
    assign port_a_line_five_level_out = link.rst_level;
    assign debug_cmd_valid_out        = cmd_valid_reg;
    assign debug_cmd_out              = cmd_reg;

    // ***********************************************************
    // reset sequencer
    // ***********************************************************

    // power-on starts in the strap state with the pin as a port line
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            state_reg        <= ST_STRAP;
            pulse_cnt_reg    <= 7'h00;
            cause_reg        <= CAUSE_RESET_VAL;
            background_reg   <= 1'b0;
            rst_pin_en_reg   <= 1'b0;
            dbg_pin_en_reg   <= 1'b1;
            armed_reg        <= 1'b0;
            forced_reg       <= 1'b0;
            clk_internal_reg <= 1'b1;
        end else begin
            case (state_reg)
                ST_STRAP: begin
                    // strap caught on the first edge after release
                    background_reg <= !link.dbg_level;
                    state_reg      <= ST_RUN;
                end
                ST_RUN: begin
                    if (any_req) begin
                        cause_reg        <= new_cause;
                        forced_reg       <= force_req;
                        armed_reg        <= 1'b0;
                        background_reg   <= 1'b0;
                        dbg_pin_en_reg   <= 1'b1;
                        clk_internal_reg <= 1'b1;
                        pulse_cnt_reg    <= 7'h00;
                        state_reg        <= ST_PULSE;
                    end else begin
                        // the enable is sticky: only power-on clears it
                        if (reset_pin_enable_in) begin
                            rst_pin_en_reg <= 1'b1;
                        end
                        if (debug_pin_disable_in) begin
                            dbg_pin_en_reg <= 1'b0;
                        end
                        if (select_crystal_in) begin
                            clk_internal_reg <= 1'b0;
                        end
                        if (byte_done && rx_byte == CMD_BACKGROUND) begin
                            armed_reg <= 1'b1;
                        end
                    end
                end
                ST_PULSE: begin
                    pulse_cnt_reg <= pulse_cnt_reg + 7'h01;
                    if (pulse_cnt_reg == 7'(RESET_PULSE_CYCLES - 1)) begin
                        state_reg <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    // wait for an outside holder to let go of the pin
                    if (!rst_pin_en_reg || link.rst_level) begin
                        // only a forced debug reset reads the strap
                        background_reg <= forced_reg &&
                                          !link.dbg_level;
                        state_reg      <= ST_RUN;
                    end
                end
                default: begin
                    state_reg <= ST_STRAP;
                end
            endcase
        end
    end

    // ***********************************************************
    // debug command assembly
    // ***********************************************************

    // bits arrive msb first; framing restarts with every reset
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            shift_reg     <= 8'h00;
            bit_cnt_reg   <= 3'h0;
            cmd_valid_reg <= 1'b0;
            cmd_reg       <= 8'h00;
        end else begin
            cmd_valid_reg <= byte_done;
            if (!running) begin
                bit_cnt_reg <= 3'h0;
            end else if (rx_valid) begin
                shift_reg   <= rx_byte;
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == 3'h7) begin
                    cmd_reg <= rx_byte;
                end
            end
        end
    end
endmodule

//--- pin_ctrl_host.sv
// far end: debug pod and external reset source on the two pins
`timescale 1ns/10ps
module pin_ctrl_host
    import pin_ctrl_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       resetn_in,
    pin_link_if.host        link,
    input  wire logic       ext_reset_in,
    input  wire logic       hold_mode_low_in,
    input  wire logic       cmd_valid_in,
    input  wire logic [7:0] cmd_byte_in,
    output logic            cmd_ready_out,
    output logic            target_reset_level_out
);
    logic [7:0] data_reg;
    logic [3:0] left_reg;
    logic       start_reg;
    logic       tx_busy;
    logic       eng_pin;
    logic       eng_oe_n;

    wire sending = (left_reg != 4'h0);

    debug_bit_engine u_engine (
        .mclk_in      (mclk_in),
        .resetn_in    (resetn_in),
        .rx_enable_in (1'b0),
        .tx_start_in  (start_reg),
        .tx_bit_in    (data_reg[7]),
        .pin_level_in (link.dbg_level),
        .tx_busy_out  (tx_busy),
        .pin_out      (eng_pin),
        .pin_oe_n_out (eng_oe_n),
        .rx_valid_out (),
        .rx_bit_out   ()
    );

    // reset source: open-drain pull low while asked
    assign link.rst_host_o    = 1'b0;
    assign link.rst_host_oe_n = !ext_reset_in;
    // strap hold wins over the serial engine
    assign link.dbg_host_o    = hold_mode_low_in ? 1'b0 : eng_pin;
    assign link.dbg_host_oe_n = hold_mode_low_in ? 1'b0 : eng_oe_n;
    assign cmd_ready_out      = !sending && !start_reg && !tx_busy;
    assign target_reset_level_out = link.rst_level;

    // byte sender: one start per bit, msb first, two idle cycles between bits
    always_ff @(posedge mclk_in) begin
        if (!resetn_in) begin
            data_reg  <= 8'h00;
            left_reg  <= 4'h0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (cmd_valid_in && cmd_ready_out) begin
                data_reg  <= cmd_byte_in;
                left_reg  <= 4'h8;
                start_reg <= 1'b1;
            end else if (sending && !tx_busy && !start_reg) begin
                if (left_reg != 4'h1) begin
                    data_reg  <= {data_reg[6:0], 1'b0};
                    start_reg <= 1'b1;
                end
                left_reg <= left_reg - 4'h1;
            end
        end
    end
endmodule

//--- pin_link_chk.sv
// concurrent checks on the pin link between the device and pod ends
`timescale 1ns/10ps
module pin_link_chk
    import pin_ctrl_pkg::*;
(
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic rst_dev_o,
    input wire logic rst_dev_oe_n,
    input wire logic rst_pullup,
    input wire logic rst_level,
    input wire logic dbg_dev_oe_n,
    input wire logic dbg_host_o,
    input wire logic dbg_host_oe_n,
    input wire logic dbg_pullup
);
    // ****************************************************************
    // pin decode, run counters and assertions
    // ****************************************************************
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!resetn_in);

    // device pulling the enabled reset pin low, pod drive states
    wire rst_drv_low = rst_pullup && !rst_dev_oe_n && !rst_dev_o;
    wire pod_low     = !dbg_host_oe_n && !dbg_host_o;
    wire pod_high    = !dbg_host_oe_n && dbg_host_o;
    int unsigned low_cnt;
    int unsigned pod_cnt;

    // run lengths; any gap restarts them so a glitch cannot hide
    always_ff @(posedge mclk_in) begin
        low_cnt <= (resetn_in && rst_drv_low) ? low_cnt + 1 : 0;
        pod_cnt <= (resetn_in && pod_low) ? pod_cnt + 1 : 0;
    end

    a_port_default: assert property (
        $rose(resetn_in) |-> !rst_pullup && dbg_pullup)
        else $error("pin defaults wrong after power-on");
    a_strap_released: assert property (
        $rose(resetn_in) |-> dbg_dev_oe_n)
        else $error("debug pin driven while strap is sampled");
    a_reset_sticky: assert property (
        rst_pullup |=> rst_pullup)
        else $error("reset pin function lost before power-on");
    a_open_drain: assert property (
        rst_pullup |-> rst_dev_oe_n || !rst_dev_o)
        else $error("enabled reset pin driven high");
    a_ext_low_reset: assert property (
        rst_pullup && rst_dev_oe_n && $fell(rst_level)
        |-> ##[1:3] rst_drv_low)
        else $error("outside low on reset pin did not reset");
    a_pulse_length: assert property (
        $fell(rst_drv_low) |-> low_cnt == RESET_PULSE_CYCLES)
        else $error("reset pin pulse has wrong length");
    a_pulse_bound: assert property (
        low_cnt <= RESET_PULSE_CYCLES)
        else $error("reset pin pulse too long");
    a_bit_low_len: assert property (
        $fell(pod_low) && pod_high
        |-> pod_cnt == LOW_CYCLES_ONE || pod_cnt == LOW_CYCLES_ZERO)
        else $error("debug bit low time wrong");
    a_speedup_short: assert property (
        pod_high |=> !pod_high)
        else $error("speedup pulse longer than one cycle");
endmodule

//--- tb_top.sv
// bench joining device and pod ends over the pin link, scenario tasks
`timescale 1ns/10ps
module tb_top
    import pin_ctrl_pkg::*;
();
    // ****************************************************************
    // signals, instances, clock and hang guard
    // ****************************************************************
    logic       mclk_in, resetn_in, rst_en, dbg_dis, xtal, wdog, lowv;
    logic       p5_data, p5_drive, p4_data, ext_rst, hold_low, cmd_valid;
    logic [7:0] cmd_byte, cause, cmd_rx;
    logic       sys_reset, bg_mode, rst_en_o, dbg_en_o, clk_int;
    logic       p5_level, cmd_seen, cmd_ready, tgt_level;
    int         n_fail, cmp_count, cycles;
    pin_link_if link();

    pin_ctrl_device pin_ctrl_device_inst (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .link(link),
        .reset_pin_enable_in(rst_en), .debug_pin_disable_in(dbg_dis),
        .select_crystal_in(xtal), .wdog_reset_req_in(wdog),
        .low_voltage_req_in(lowv), .port_a_line_five_data_in(p5_data),
        .port_a_line_five_drive_in(p5_drive),
        .port_a_line_four_data_in(p4_data), .sys_reset_out(sys_reset),
        .background_mode_out(bg_mode), .reset_pin_enable_out(rst_en_o),
        .debug_pin_enable_out(dbg_en_o), .clock_internal_out(clk_int),
        .reset_cause_out(cause), .port_a_line_five_level_out(p5_level),
        .debug_cmd_valid_out(cmd_seen), .debug_cmd_out(cmd_rx));
    pin_ctrl_host pin_ctrl_host_inst (
        .mclk_in(mclk_in), .resetn_in(resetn_in), .link(link),
        .ext_reset_in(ext_rst), .hold_mode_low_in(hold_low),
        .cmd_valid_in(cmd_valid), .cmd_byte_in(cmd_byte),
        .cmd_ready_out(cmd_ready), .target_reset_level_out(tgt_level));
    pin_link_chk pin_link_chk_inst (
        .mclk_in(mclk_in), .resetn_in(resetn_in),
        .rst_dev_o(link.rst_dev_o), .rst_dev_oe_n(link.rst_dev_oe_n),
        .rst_pullup(link.rst_pullup), .rst_level(link.rst_level),
        .dbg_dev_oe_n(link.dbg_dev_oe_n), .dbg_host_o(link.dbg_host_o),
        .dbg_host_oe_n(link.dbg_host_oe_n), .dbg_pullup(link.dbg_pullup));

    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end

    // the run needs well under two thousand cycles; far beyond that is a hang
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // power-on reset for 3 cycles; strap held over the sampling edge
    task automatic por(input logic h);
        @(posedge mclk_in);
        hold_low <= h;
        resetn_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        hold_low <= 1'b0;
        @(negedge mclk_in);
    endtask

    // byte handshake: wait for ready, then valid held for one cycle
    task automatic send_byte(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge mclk_in);
        while (cmd_ready !== 1'b1 && n < 400) begin
            @(negedge mclk_in);
            n++;
        end
        if (n >= 400) n_fail++;
        @(posedge mclk_in);
        cmd_byte <= b;
        cmd_valid <= 1'b1;
        @(posedge mclk_in);
        cmd_valid <= 1'b0;
    endtask

    task automatic expect_byte(input logic [7:0] b);
        int n;
        n = 0;
        while (cmd_seen !== 1'b1 && n < 400) begin
            @(negedge mclk_in);
            n++;
        end
        if (n >= 400) n_fail++;
        check(cmd_rx, b);
    endtask

    // waits for a reset, drops requests, sets strap, counts pin low time
    task automatic run_reset(input logic h, output int low);
        int n;
        n = 0;
        while (sys_reset !== 1'b1 && n < 400) begin
            @(negedge mclk_in);
            n++;
        end
        if (n >= 400) n_fail++;
        low = (link.rst_dev_oe_n === 1'b0);
        @(posedge mclk_in);
        ext_rst <= 1'b0;
        wdog <= 1'b0;
        lowv <= 1'b0;
        hold_low <= h;
        n = 0;
        @(negedge mclk_in);
        while (sys_reset === 1'b1 && n < 400) begin
            if (link.rst_dev_oe_n === 1'b0) low++;
            @(negedge mclk_in);
            n++;
        end
        if (n >= 400) n_fail++;
        @(posedge mclk_in);
        hold_low <= 1'b0;
        @(negedge mclk_in);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_power_on();
        por(1'b0);
        check(8'(bg_mode), 8'h00);
        check(cause, CAUSE_RESET_VAL);
        check(8'(rst_en_o), 8'h00);
        check(8'(link.dbg_pullup), 8'h01);
        check(8'(clk_int), 8'h01);
        @(posedge mclk_in);
        p5_drive <= 1'b1;
        repeat (3) @(negedge mclk_in);
        check(8'({p5_level, tgt_level, sys_reset}), 8'h00);
        @(posedge mclk_in);
        p5_drive <= 1'b0;
        $display("test power_on done");
    endtask

    task automatic t_strap();
        por(1'b1);
        check(8'({sys_reset, bg_mode}), 8'h01);
        $display("test strap done");
    endtask

    task automatic t_command();
        send_byte(8'h5a);
        expect_byte(8'h5a);
        send_byte(8'ha5);
        expect_byte(8'ha5);
        $display("test command done");
    endtask

    // pin reset with the strap held low must still come back normal
    task automatic t_pin_reset();
        int low;
        @(posedge mclk_in);
        {rst_en, dbg_dis, xtal} <= 3'b111;
        @(posedge mclk_in);
        {rst_en, dbg_dis, xtal} <= 3'b000;
        repeat (2) @(negedge mclk_in);
        check(8'({rst_en_o, link.rst_pullup}), 8'h03);
        check(8'({dbg_en_o, link.dbg_pullup}), 8'h00);
        check(8'(link.dbg_level), 8'h00);
        check(8'(clk_int), 8'h00);
        @(posedge mclk_in);
        p4_data <= 1'b1;
        hold_low <= 1'b1;
        ext_rst <= 1'b1;
        run_reset(1'b1, low);
        check(8'(low), 8'(RESET_PULSE_CYCLES));
        check(cause, 8'h40);
        check(8'(bg_mode), 8'h00);
        check(8'({rst_en_o, dbg_en_o, link.dbg_pullup}), 8'h07);
        check(8'(clk_int), 8'h01);
        $display("test pin_reset done");
    endtask

    task automatic t_internal();
        int low;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_in);
            wdog <= (i == 0);
            lowv <= (i == 1);
            run_reset(1'b0, low);
            check(8'(low), 8'(RESET_PULSE_CYCLES));
            check(cause, (i == 0) ? 8'h20 : 8'h02);
        end
        $display("test internal done");
    endtask

    // forced debug reset, strap released then held by the pod
    task automatic t_force();
        int low;
        for (int h = 0; h < 2; h++) begin
            send_byte(CMD_BACKGROUND);
            send_byte(CMD_FORCE_RESET);
            run_reset(h == 1, low);
            check(8'(bg_mode), 8'(h == 1));
            check(8'(low), 8'(RESET_PULSE_CYCLES));
            check(cause, 8'h04);
            check(8'(dbg_en_o), 8'h01);
        end
        $display("test force done");
    endtask

    initial begin
        {rst_en, dbg_dis, xtal, wdog, lowv, p5_data, p5_drive} = '0;
        {p4_data, ext_rst, hold_low, cmd_valid, cmd_byte} = '0;
        resetn_in = 1'b0;
        n_fail = 0;
        cmp_count = 0;
        cycles = 0;
        t_power_on();
        t_strap();
        t_command();
        t_pin_reset();
        t_internal();
        t_force();
        print_verdict();
    end
endmodule
